// ===== hdl/bank4_error_syndrome_logger.sv
// Bank-4 error status logger: builds the upper and model-specific status fields
// Function
// - Eight-bit correctable count at bits 39:32, cleared only by cold reset.
// - Count reads 1 after first log, increments, saturates at 255.
// - Bits 41:40 hold extra-info format, meaningful while its valid flag is set.
// - Bits 51:44 hold the syndrome when the syndrome-valid flag is set.
// - Bit 52 set only when a correctable event supplies a syndrome.
// - Bits 54:53 health: 00 none, 01 green, 10 yellow, 11 reserved.
// - Bits 56:32 use one layout for cache, bus and internal errors.
// - Cache way code 000/100 none, 001 multi corr, 010 multi uncorr, 011 tag.
// - Cache way code 101 single corr, 110 single uncorr, 111 mixed.
// - Cache error: bits 20:19 zero, bits 31:21 fixed pattern 0010_0000_000.
// - Bus flags: 16 request, 17/18 core addr, 20 response, 21 inbound data.
// - Bus flags: 22/23 core data, 24 defer parity, 25 inbound data ECC.
// - Bus flags: 26 data strobe glitch, 27 request strobe glitch; 19, 31:28 reserved.
// - A logged bus error carries exactly one detail flag.
// - Inbound data ECC may be either kind; syndrome only when correctable.
// - Every other bus error is logged uncorrectable.
// - Bits 15:0 give the type code for cache, bus or internal errors.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "bank4_defs.svh"

module bank4_error_syndrome_logger (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Error event from the detectors
    input wire logic i_ev_valid,
    input wire bank4_pkg::event_s i_ev,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Status out and interrupt
    output logic [63:0] o_status,
    output logic o_irq
);

    typedef enum logic [1:0] {
        ST_EMPTY = 2'b01,
        ST_VALID = 2'b10
    } log_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Field builders

    // Bus detail flags keep their positions; reserved positions always read low
    function automatic logic [15:0] bus_code(input logic [11:0] f);
        logic [15:0] m;
        m = 16'h0000;
        m[`BUS_REQ_PAR] = f[`BUS_REQ_PAR];
        m[`BUS_C0_ADDR] = f[`BUS_C0_ADDR];
        m[`BUS_C1_ADDR] = f[`BUS_C1_ADDR];
        m[`BUS_RSP_PAR] = f[`BUS_RSP_PAR];
        m[`BUS_IN_PAR] = f[`BUS_IN_PAR];
        m[`BUS_C0_DATA] = f[`BUS_C0_DATA];
        m[`BUS_C1_DATA] = f[`BUS_C1_DATA];
        m[`BUS_DEFER_PAR] = f[`BUS_DEFER_PAR];
        m[`BUS_ECC_BIT] = f[`BUS_ECC_BIT];
        m[`BUS_DATA_GLITCH] = f[`BUS_DATA_GLITCH];
        m[`BUS_REQ_GLITCH] = f[`BUS_REQ_GLITCH];
        return m;
    endfunction

    function automatic logic [15:0] model_code(input bank4_pkg::event_s ev);
        logic [15:0] m;
        m = 16'h0000;
        case (ev.etype)
            bank4_pkg::ERR_CACHE: begin
                m = {`CACHE_FIXED, ev.way_code};
            end
            bank4_pkg::ERR_BUS: begin
                m = bus_code(ev.bus_flags);
            end
            default: begin
                m = 16'h0000;
            end
        endcase
        return m;
    endfunction

    function automatic logic [15:0] arch_code(input bank4_pkg::err_type_e t);
        logic [15:0] c;
        c = `CODE_INT;
        case (t)
            bank4_pkg::ERR_CACHE: begin
                c = `CODE_CACHE;
            end
            bank4_pkg::ERR_BUS: begin
                c = `CODE_BUS;
            end
            default: begin
                c = `CODE_INT;
            end
        endcase
        return c;
    endfunction

    function automatic logic one_hot(input logic [15:0] v);
        return (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
    endfunction

    // Saturating step: zero goes to the first value, the top value holds
    function automatic logic [7:0] sat_inc(input logic [7:0] c);
        logic [7:0] n;
        n = c;
        if (c == `CNT_ZERO) begin
            n = `CNT_FIRST;
        end else if (c != `CNT_MAX) begin
            n = c + 8'h01;
        end
        return n;
    endfunction

    // Register write decode, shared by the log and register groups
    function automatic logic wr_hit(input logic wr, input logic [3:0] a,
                                    input logic [3:0] idx);
        return wr && (a == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event qualification

    logic [15:0] ev_model;
    logic ev_is_bus;
    logic ev_bus_ecc;
    logic ev_ok;
    logic ev_uc;
    logic ev_syn;
    logic ev_corr;

    always_comb begin
        ev_model = model_code(i_ev);
        ev_is_bus = (i_ev.etype == bank4_pkg::ERR_BUS);
        ev_bus_ecc = ev_model[`BUS_ECC_BIT];
        // A bus event without a single detail flag is dropped
        ev_ok = i_ev_valid && (!ev_is_bus || one_hot(ev_model));
        // Only inbound data ECC may be correctable on the bus
        if (ev_is_bus) begin
            ev_uc = !ev_bus_ecc || i_ev.uncorr;
        end else begin
            ev_uc = i_ev.uncorr;
        end
        ev_syn = !ev_uc && i_ev.has_syn;
        ev_corr = !ev_uc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode

    logic wr_ctrl;
    logic wr_irq_clr;
    logic wr_irq_en;

    always_comb begin
        wr_ctrl = wr_hit(i_wr, i_addr, `ADDR_CTRL);
        wr_irq_clr = wr_hit(i_wr, i_addr, `ADDR_IRQ_CLR);
        wr_irq_en = wr_hit(i_wr, i_addr, `ADDR_IRQ_EN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status log state

    log_state_e state_ff, nxt_state;
    bank4_pkg::status_s stat_ff, nxt_stat;
    logic [7:0] count_ff, nxt_count;
    logic health_en_ff, nxt_health_en;
    logic [2:0] irq_stat_ff, nxt_irq_stat;
    logic [2:0] irq_en_ff, nxt_irq_en;
    logic [31:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic take;
    logic over_ev;
    logic sat_ev;
    logic [63:0] stat_word;
    logic [63:0] nxt_status;

    // Packs the struct into the architectural 64-bit image
    function automatic logic [63:0] pack_status(input bank4_pkg::status_s s,
                                                input logic [7:0] cnt);
        logic [63:0] w;
        w = 64'h0;
        w[`B_VAL] = s.val;
        w[`B_OVER] = s.over;
        w[`B_UC] = s.uc;
        w[`B_EXTRA_INFO_VALID_FLAG] = s.extra_info_valid_flag;
        w[`B_PCC] = s.context_corrupt_flag;
        w[`F_RSVD_HI] = 2'h0;
        w[`F_HEALTH] = s.health;
        w[`B_SYNV] = s.syn_valid;
        w[`F_SYN] = s.syn_valid ? s.syndrome : 8'h00;
        w[`F_RSVD_LO] = 2'h0;
        w[`F_FMT] = s.extra_info_valid_flag ? s.misc_fmt : 2'h0;
        w[`F_COUNT] = cnt;
        w[`F_MODEL] = s.model_code;
        w[`F_ARCH] = s.arch_code;
        return w;
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_stat = stat_ff;
        nxt_count = count_ff;
        over_ev = 1'b0;
        // Uncorrected entries are never overwritten; corrected ones may be
        take = ev_ok && !(state_ff == ST_VALID && stat_ff.uc);
        // Overflow marks any event not dropped that finds the entry already valid
        if (ev_ok && state_ff == ST_VALID) begin
            over_ev = 1'b1;
        end
        // Count saturates; only cold reset clears it
        if (ev_ok && ev_corr) begin
            nxt_count = sat_inc(count_ff);
        end
        sat_ev = ev_ok && ev_corr && (count_ff != `CNT_MAX) && (nxt_count == `CNT_MAX);
        if (take) begin
            nxt_stat.val = 1'b1;
            nxt_stat.uc = ev_uc;
            nxt_stat.context_corrupt_flag = ev_uc;
            nxt_stat.extra_info_valid_flag = i_ev.extra_info_valid_flag;
            nxt_stat.misc_fmt = i_ev.misc_fmt;
            nxt_stat.syn_valid = ev_syn;
            nxt_stat.syndrome = ev_syn ? i_ev.syndrome : 8'h00;
            // Reserved health code is demoted to no tracking
            if (i_ev.health == `HEALTH_RSVD || !health_en_ff) begin
                nxt_stat.health = `HEALTH_NONE;
            end else begin
                nxt_stat.health = i_ev.health;
            end
            nxt_stat.model_code = ev_model;
            nxt_stat.arch_code = arch_code(i_ev.etype);
            nxt_state = ST_VALID;
        end
        if (over_ev) begin
            nxt_stat.over = 1'b1;
        end
        // Software clears valid/over; a same-cycle event wins
        if (wr_ctrl && i_wdata[`CTRL_CLEAR] && !ev_ok) begin
            nxt_stat.val = 1'b0;
            nxt_stat.over = 1'b0;
            nxt_state = ST_EMPTY;
        end
        case (state_ff)
            ST_EMPTY, ST_VALID: begin
            end
            default: begin
                nxt_state = ST_EMPTY;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_ff <= ST_EMPTY;
            stat_ff <= '0;
            count_ff <= `CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            stat_ff <= nxt_stat;
            count_ff <= nxt_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers, interrupts and read data

    always_comb begin
        stat_word = pack_status(stat_ff, count_ff);
        // Image is built here so the output pin is fed by a flop only
        nxt_status = pack_status(nxt_stat, nxt_count);
        nxt_health_en = health_en_ff;
        nxt_irq_en = irq_en_ff;
        nxt_irq_stat = irq_stat_ff;
        if (wr_ctrl) begin
            nxt_health_en = i_wdata[`CTRL_HEALTH];
        end
        if (wr_irq_en) begin
            nxt_irq_en = i_wdata[2:0];
        end
        if (wr_irq_clr) begin
            nxt_irq_stat = irq_stat_ff & ~i_wdata[2:0];
        end
        // Sets after clears so that a coincident event is kept
        if (take) begin
            nxt_irq_stat[`IRQ_LOG] = 1'b1;
        end
        if (over_ev) begin
            nxt_irq_stat[`IRQ_OVER] = 1'b1;
        end
        if (sat_ev) begin
            nxt_irq_stat[`IRQ_SAT] = 1'b1;
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_en);
        nxt_rdata = 32'h0000_0000;
        if (i_rd) begin
            // Write-only and unmapped indices read as zero
            case (i_addr)
                `ADDR_STAT_LO: begin
                    nxt_rdata = stat_word[31:0];
                end
                `ADDR_STAT_HI: begin
                    nxt_rdata = stat_word[63:32];
                end
                `ADDR_CTRL: begin
                    nxt_rdata = {30'h0, health_en_ff, 1'b0};
                end
                `ADDR_IRQ_STAT: begin
                    nxt_rdata = {29'h0, irq_stat_ff};
                end
                `ADDR_IRQ_EN: begin
                    nxt_rdata = {29'h0, irq_en_ff};
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            health_en_ff <= 1'b1;
            irq_en_ff <= 3'h0;
            irq_stat_ff <= 3'h0;
            rdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            o_status <= 64'h0;
        end else begin
            health_en_ff <= nxt_health_en;
            irq_en_ff <= nxt_irq_en;
            irq_stat_ff <= nxt_irq_stat;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            o_status <= nxt_status;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_irq = irq_ff;

endmodule

// ===== hdl/bank4_defs.svh
// Offsets, field positions, codes and reset values of the bank-4 status logger
`ifndef BANK4_DEFS_SVH
`define BANK4_DEFS_SVH

// Register indices on the plain register port
`define ADDR_STAT_LO 4'h0
`define ADDR_STAT_HI 4'h1
`define ADDR_CTRL 4'h2
`define ADDR_IRQ_STAT 4'h3
`define ADDR_IRQ_CLR 4'h4
`define ADDR_IRQ_EN 4'h5

// Control register bits
`define CTRL_CLEAR 0
`define CTRL_HEALTH 1

// Status field positions
`define B_VAL 63
`define B_UC 61
`define B_EXTRA_INFO_VALID_FLAG 59
`define B_PCC 57
`define B_OVER 62
`define B_SYNV 52
`define F_RSVD_HI 56:55
`define F_HEALTH 54:53
`define F_SYN 51:44
`define F_RSVD_LO 43:42
`define F_FMT 41:40
`define F_COUNT 39:32
`define F_MODEL 31:16
`define F_ARCH 15:0
`define CNT_MAX 8'hFF
`define CNT_FIRST 8'h01
`define CNT_ZERO 8'h00

// Low-order type codes
`define CODE_CACHE 16'h010B
`define CODE_BUS 16'h0E0F
`define CODE_INT 16'h0400

// Cache model-specific constant upper part (bits 31:19)
`define CACHE_FIXED 13'h0400

// Bus detail flag positions within 31:16
`define BUS_FLAG_MASK 16'h0FF7
`define BUS_REQ_PAR 0
`define BUS_C0_ADDR 1
`define BUS_C1_ADDR 2
`define BUS_RSP_PAR 4
`define BUS_IN_PAR 5
`define BUS_C0_DATA 6
`define BUS_C1_DATA 7
`define BUS_DEFER_PAR 8
`define BUS_ECC_BIT 9
`define BUS_DATA_GLITCH 10
`define BUS_REQ_GLITCH 11

// Health codes
`define HEALTH_NONE 2'h0
`define HEALTH_GREEN 2'h1
`define HEALTH_YELLOW 2'h2
`define HEALTH_RSVD 2'h3

// Interrupt bits
`define IRQ_LOG 0
`define IRQ_OVER 1
`define IRQ_SAT 2

`endif

// ===== hdl/bank4_pkg.sv
// Types shared by the bank-4 status logger
package bank4_pkg;
    typedef enum logic [1:0] {
        ERR_CACHE = 2'h0,
        ERR_BUS = 2'h1,
        ERR_INTERNAL = 2'h2
    } err_type_e;

    typedef struct packed {
        logic [7:0] count;
        logic [1:0] misc_fmt;
        logic [7:0] syndrome;
        logic syn_valid;
        logic [1:0] health;
        logic [15:0] model_code;
        logic [15:0] arch_code;
        logic val;
        logic over;
        logic uc;
        logic extra_info_valid_flag;
        logic context_corrupt_flag;
    } status_s;

    typedef struct packed {
        err_type_e etype;
        logic [2:0] way_code;
        logic [11:0] bus_flags;
        logic uncorr;
        logic has_syn;
        logic [7:0] syndrome;
        logic extra_info_valid_flag;
        logic [1:0] misc_fmt;
        logic [1:0] health;
    } event_s;
endpackage

// ===== dv/bank4_error_syndrome_logger_monitor.sv
// Port-level assertions for the bank-4 status logger
`timescale 1ns/1ns
module bank4_error_syndrome_logger_monitor (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Watched ports
    input wire logic i_ev_valid,
    input wire bank4_pkg::event_s i_ev,
    input wire logic i_wr,
    input wire logic [63:0] o_status
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    ////////////////////////////////////////////////////////////////////////////////
    // Only events into an empty entry have a fully known result
    sequence s_fresh;
        i_ev_valid && !o_status[63] && !i_wr;
    endsequence
    sequence s_plain;
        s_fresh ##0 i_ev.etype != bank4_pkg::ERR_BUS;
    endsequence
    sequence s_bus_one;
        s_fresh ##0 i_ev.etype == bank4_pkg::ERR_BUS && !i_ev.bus_flags[3]
            && $onehot(i_ev.bus_flags);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_cache_code: assert property (
        s_fresh ##0 i_ev.etype == bank4_pkg::ERR_CACHE |=>
        o_status[31:0] == {11'h100, 2'h0, $past(i_ev.way_code), 16'h010B})
        else $error("cache code wrong");
    a_bus_code: assert property (
        s_bus_one |=> o_status[31:0] == {4'h0, $past(i_ev.bus_flags), 16'h0E0F})
        else $error("bus code wrong");
    a_bus_uncorr: assert property (
        s_bus_one ##0 !i_ev.bus_flags[9] |=> o_status[61] && o_status[57])
        else $error("bus error not uncorrected");
    a_bus_ecc: assert property (
        s_bus_one ##0 i_ev.bus_flags[9] |=> o_status[61] == $past(i_ev.uncorr))
        else $error("bus ecc kind wrong");
    a_bus_refused: assert property (
        i_ev_valid && i_ev.etype == bank4_pkg::ERR_BUS && !i_wr
        && !$onehot(i_ev.bus_flags & 12'hFF7) |=> $stable(o_status))
        else $error("bad bus event logged");
    a_syn_flag: assert property (
        s_plain |=> o_status[52] == ($past(i_ev.has_syn) && !$past(i_ev.uncorr)))
        else $error("syndrome flag wrong");
    a_syn_value: assert property (
        s_plain ##0 i_ev.has_syn && !i_ev.uncorr |=> o_status[51:44] == $past(i_ev.syndrome))
        else $error("syndrome wrong");
    a_health_code: assert property (
        s_plain ##0 !i_ev.uncorr |=> o_status[54:53] ==
        ($past(i_ev.health) == 2'h3 ? 2'h0 : $past(i_ev.health)))
        else $error("health wrong");
    a_misc_format: assert property (
        s_plain |=> o_status[59] == $past(i_ev.extra_info_valid_flag)
        && o_status[41:40] == ($past(i_ev.extra_info_valid_flag) ? $past(i_ev.misc_fmt) : 2'h0))
        else $error("format field wrong");
    a_reserved_zero: assert property (
        o_status[43:42] == 2'h0 && o_status[56:55] == 2'h0)
        else $error("reserved bits set");
    a_count_step: assert property (
        i_ev_valid && i_ev.etype != bank4_pkg::ERR_BUS && !i_ev.uncorr && !o_status[61]
        && o_status[39:32] != 8'hFF |=> o_status[39:32] == $past(o_status[39:32]) + 8'h01)
        else $error("count step wrong");
    a_count_hold: assert property (
        !i_ev_valid || o_status[39:32] == 8'hFF |=> $stable(o_status[39:32]))
        else $error("count moved");
endmodule

// ===== dv/bank4_error_syndrome_logger_test.sv
// Self-checking bench for the bank-4 status logger
`timescale 1ns/1ns
module bank4_error_syndrome_logger_test;
    logic I_CLOCK = 1'b0;
    logic I_NRST = 1'b0;
    logic i_ev_valid = 1'b0;
    bank4_pkg::event_s i_ev = '0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [63:0] o_status;
    logic o_irq;
    int num_errors = 0;
    int checked = 0;
    integer seed = 22805;
    logic [7:0] cnt = 8'h00;
    logic [63:0] exp_s;
    logic [63:0] msk;

    always #2 I_CLOCK = ~I_CLOCK;

    bank4_error_syndrome_logger uut (.I_CLOCK, .I_NRST, .i_ev_valid, .i_ev, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_status, .o_irq);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic reg_io(input logic [3:0] a, input logic [31:0] d, input logic wr);
        @(posedge I_CLOCK);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= wr;
        i_rd <= !wr;
        @(posedge I_CLOCK);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1;
    endtask
    task automatic settle;
        @(posedge I_CLOCK);
        #1;
    endtask
    function automatic bank4_pkg::event_s rnd_ev(input bank4_pkg::err_type_e t);
        bank4_pkg::event_s e;
        e = $random(seed);
        e.etype = t;
        return e;
    endfunction
    // Clears the entry first so the event lands in an empty register
    task automatic fresh(input bank4_pkg::event_s e);
        logic uc;
        reg_io(4'h2, 32'h3, 1'b1);
        @(posedge I_CLOCK);
        i_ev <= e;
        i_ev_valid <= 1'b1;
        @(posedge I_CLOCK);
        i_ev_valid <= 1'b0;
        #1;
        uc = e.uncorr || (e.etype == bank4_pkg::ERR_BUS && !e.bus_flags[9]);
        if (!uc && cnt != 8'hFF) cnt++;
        exp_s = {1'b1, 1'b0, uc, 1'b0, e.extra_info_valid_flag, 1'b0, uc, 2'h0, uc ? 2'h0 : e.health,
            !uc && e.has_syn, e.syndrome, 2'h0, e.extra_info_valid_flag ? e.misc_fmt : 2'h0, cnt, 32'h0};
        if (e.health == 2'h3) exp_s[54:53] = 2'h0;
        // Health is undefined under an uncorrected error, syndrome without its flag
        msk = {9'h1FF, !uc, !uc, 1'b1, exp_s[52] ? 8'hFF : 8'h00, 44'hFFF_FFFF_FFFF};
        case (e.etype)
            bank4_pkg::ERR_CACHE: exp_s[31:0] = {11'h100, 2'h0, e.way_code, 16'h010B};
            bank4_pkg::ERR_BUS: exp_s[31:0] = {4'h0, e.bus_flags, 16'h0E0F};
            default: exp_s[31:0] = 32'h0400;
        endcase
        if (e.etype == bank4_pkg::ERR_INTERNAL) msk[31:16] = 16'h0;
        check(o_status & msk, exp_s & msk);
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge I_CLOCK);
        num_errors++;
        finish_test();
    end

    initial begin
        bank4_pkg::event_s e;
        logic [63:0] prev;
        repeat (20) @(posedge I_CLOCK);
        I_NRST <= 1'b1;
        settle();
        check(o_status, 64'h0);
        reg_io(4'h5, 32'h7, 1'b1);
        for (int w = 0; w < 8; w++) begin
            e = rnd_ev(bank4_pkg::ERR_CACHE);
            e.way_code = w[2:0];
            fresh(e);
        end
        settle();
        check(o_irq, 1'b1);
        for (int b = 0; b < 12; b++) begin
            e = rnd_ev(bank4_pkg::ERR_BUS);
            e.bus_flags = (b == 3) ? 12'h200 : 12'h001 << b;
            fresh(e);
        end
        prev = o_status;
        e.bus_flags = 12'h041;
        @(posedge I_CLOCK);
        i_ev <= e;
        i_ev_valid <= 1'b1;
        @(posedge I_CLOCK);
        i_ev_valid <= 1'b0;
        settle();
        check(o_status, prev);
        reg_io(4'h4, 32'h7, 1'b1);
        reg_io(4'h5, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) fresh(rnd_ev(bank4_pkg::ERR_INTERNAL));
        settle();
        check(o_irq, 1'b0);
        reg_io(4'h3, 32'h0, 1'b0);
        check(o_rdata, 32'h1);
        reg_io(4'h1, 32'h0, 1'b0);
        check(o_rdata & msk[63:32], exp_s[63:32] & msk[63:32]);
        reg_io(4'h0, 32'h0, 1'b0);
        check(o_rdata & msk[31:0], exp_s[31:0] & msk[31:0]);
        reg_io(4'hF, 32'h0, 1'b0);
        check(o_rdata, 32'h0);
        reg_io(4'h5, 32'h4, 1'b1);
        reg_io(4'h2, 32'h3, 1'b1);
        // Back-to-back correctable events drive the count into saturation
        for (int i = 0; i < 300; i++) begin
            @(posedge I_CLOCK);
            e = rnd_ev(bank4_pkg::ERR_INTERNAL);
            e.uncorr = 1'b0;
            i_ev <= e;
            i_ev_valid <= 1'b1;
        end
        @(posedge I_CLOCK);
        i_ev_valid <= 1'b0;
        settle();
        check(o_status[39:32], 8'hFF);
        check(o_irq, 1'b1);
        @(posedge I_CLOCK);
        I_NRST <= 1'b0;
        settle();
        check(o_status, 64'h0);
        check({o_irq, o_rdata}, 33'h0);
        @(posedge I_CLOCK);
        I_NRST <= 1'b1;
        // First correctable event after a cold reset must read a count of one
        cnt = 8'h00;
        e.uncorr = 1'b0;
        fresh(e);
        finish_test();
    end
endmodule

bind bank4_error_syndrome_logger bank4_error_syndrome_logger_monitor mon (.I_CLOCK, .I_NRST,
    .i_ev_valid, .i_ev, .i_wr, .o_status);
